// file: inc/dss_cfg.svh
// constants of the drive start/stop sequencer
`ifndef DSS_CFG_SVH
`define DSS_CFG_SVH
`define DSS_CLK_HZ 20000000
`define DSS_TICK_MS 10
`define DSS_TPS 16'h000A
`define DSS_NREG 4'hF
`define DSS_NCFG 4'hD
`define DSS_R_CTRL 4'h0
`define DSS_R_MODE 4'h1
`define DSS_R_FREF 4'h2
`define DSS_R_FSTART 4'h3
`define DSS_R_FLIM 4'h4
`define DSS_R_FMAX 4'h5
`define DSS_R_RAMP 4'h6
`define DSS_R_SBRK 4'h7
`define DSS_R_TBRK 4'h8
`define DSS_R_TBFQ 4'h9
`define DSS_R_SCRV 4'hA
`define DSS_R_BRKC 4'hB
`define DSS_R_TFREE 4'hC
`define DSS_R_STAT 4'hD
`define DSS_R_FOUT 4'hE
`define DSS_LO 15:0
`define DSS_HI 31:16
`define DSS_F_RUN 0
`define DSS_F_FCLR 1
`define DSS_F_START 1:0
`define DSS_F_SHAPE 3:2
`define DSS_F_STOP 5:4
`define DSS_F_BMETH 7:6
`define DSS_F_TREAT 9:8
`define DSS_F_LARGE 16
`define DSS_F_PTYPE 17
`define DSS_RST_MODE 32'h0000_0040
`define DSS_RST_FSTART 32'h0000_0032
`define DSS_RST_FLIM 32'h1388_0000
`define DSS_RST_FMAX 32'h0000_1388
`define DSS_RST_RAMP 32'h003C_003C
`define DSS_RST_SCRV 32'h0258_00C8
`define DSS_RST_BRKC 32'h0000_02BC
`define DSS_RST_TFREE 32'h0000_0014
`define DSS_CUR_G 16'h03E8
`define DSS_CUR_P 16'h0320
`define DSS_TIME_MAX 16'h012C
`define DSS_HOLD_MAX 16'h0064
`define DSS_FBRK_CAP 16'h1388
`define DSS_WAIT_MAX 16'h03E8
`define DSS_SC_IMIN 16'h0064
`define DSS_SC_IMAX 16'h01F4
`define DSS_SC_RMIN 16'h0064
`define DSS_SC_RMAX 16'h0320
`define DSS_SC_SUM 16'h0384
`define DSS_PERMIL 32'h0000_03E8
`define DSS_THR_MIN 16'h0168
`define DSS_THR_MAX 16'h02EE
`define DSS_THR_LARGE 16'h02C6
`define DSS_LOSS_V 16'h012C
`define DSS_TF_MIN 16'h0005
`define DSS_TF_MAX 16'h0064
`define DSS_KFULL 7'h40
`endif

// file: inc/dss_pkg.sv
// types of the drive start/stop sequencer
package dss_pkg;
  typedef enum logic [2:0] {
    DSS_IDLE = 3'b000, DSS_SDC = 3'b001, DSS_SHOLD = 3'b010, DSS_RUN = 3'b011,
    DSS_DECEL = 3'b100, DSS_BWAIT = 3'b101, DSS_TDC = 3'b110
  } dss_state_t;
  typedef struct packed {
    logic dc_on;
    logic [15:0] dc_level;
    logic res_on;
    logic flux_on;
    logic [15:0] duty;
  } dss_brake_t;
endpackage

// file: core/dss_sequencer.sv
// drive start/stop sequencer with its register slave
`timescale 1ns/1ps
`include "dss_cfg.svh"
module dss_sequencer
  import dss_pkg::*;
#(
  parameter int CS_CYC = `DSS_CLK_HZ / (1000 / `DSS_TICK_MS)
)
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [15:0] bus_volt_i,
  input wire logic undervolt_i,
  output logic [15:0] freq_cmd_o,
  output dss_brake_t brake_o,
  output logic pwm_inhibit_o,
  output logic undervolt_alarm_o,
  output logic undervolt_fault_o,
  output logic fault_record_o
);

  function automatic logic [15:0] umin(input logic [15:0] a, input logic [15:0] b);
    return (a < b) ? a : b;
  endfunction

  function automatic logic [15:0] umax(input logic [15:0] a, input logic [15:0] b);
    return (a > b) ? a : b;
  endfunction

  function automatic logic [31:0] rst_val(input logic [3:0] i);
    case (i)
      `DSS_R_MODE: return `DSS_RST_MODE;
      `DSS_R_FSTART: return `DSS_RST_FSTART;
      `DSS_R_FLIM: return `DSS_RST_FLIM;
      `DSS_R_FMAX: return `DSS_RST_FMAX;
      `DSS_R_RAMP: return `DSS_RST_RAMP;
      `DSS_R_SCRV: return `DSS_RST_SCRV;
      `DSS_R_BRKC: return `DSS_RST_BRKC;
      `DSS_R_TFREE: return `DSS_RST_TFREE;
      default: return 32'h0000_0000;
    endcase
  endfunction

  logic [31:0] cfg_reg [0:12];
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rd_mux;
  logic [3:0] idx;
  logic mapped;
  logic wr_fire;
  logic fclr;
  dss_state_t st_reg;
  dss_state_t st_next;
  logic [31:0] tick_cnt_reg;
  logic tick;
  logic [15:0] tmr_reg;
  logic [15:0] uv_tmr_reg;
  logic [15:0] freq_reg;
  logic [15:0] org_reg;
  logic [47:0] acc_reg;
  logic [6:0] k_reg;
  logic alarm_reg;
  logic pend_reg;
  logic fault_reg;
  logic rec_reg;
  logic inhibit_reg;
  dss_brake_t brake_reg;
  logic run_req;
  logic [15:0] cur_max, sb_cur, sb_t, tb_cur, tb_t, fbrk, bwait, hold_t;
  logic [15:0] sc_init, sc_rise, thr, tf_t, acc_t, dec_t, ref_f, fstart;
  logic [15:0] f_lo, f_hi, fmax, target;
  logic [1:0] start_mode, shape, stop_mode, bmeth, treat;
  logic sc_ok;
  logic [47:0] den, inc;
  logic [31:0] done, span;
  logic ph1, ph3;
  logic uv_trip;

  // ----------------------------------------------------------------
  // register bus slave
  // ----------------------------------------------------------------
  // one wait state per access so read data are registered when taken
  assign idx = avs_address_i[5:2];
  assign mapped = (avs_address_i[7:6] == 2'h0) && (idx < `DSS_NREG);
  assign wr_fire = avs_write_i & ack_reg & mapped & (idx < `DSS_NCFG);
  assign fclr = wr_fire & (idx == `DSS_R_CTRL) & avs_byteenable_i[0]
    & avs_writedata_i[`DSS_F_FCLR];
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_reg;
  assign avs_readdata_o = rdata_reg;

  // acknowledge toggles so back-to-back requests each see one wait
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      ack_reg <= 1'b0;
    else
      ack_reg <= (avs_read_i | avs_write_i) & ~ack_reg;
  end

  // read mux; unmapped words read as zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (mapped)
    begin
      case (idx)
        `DSS_R_STAT: rd_mux = {25'h0, pend_reg, fault_reg, alarm_reg, 1'b0, st_reg};
        `DSS_R_FOUT: rd_mux = {16'h0, freq_reg};
        default: rd_mux = cfg_reg[idx];
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_reg <= 32'h0000_0000;
    else if (avs_read_i & ~ack_reg)
      rdata_reg <= rd_mux;
  end

  // settings written with byte lanes; status words are read only
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < 13; i++)
        cfg_reg[i] <= rst_val(4'(i));
    end
    else if (wr_fire)
    begin
      for (int b = 0; b < 4; b++)
        if (avs_byteenable_i[b])
          cfg_reg[idx][8*b +: 8] <= avs_writedata_i[8*b +: 8];
    end
  end

  // ----------------------------------------------------------------
  // settings with range clamps
  // ----------------------------------------------------------------
  always_comb
  begin
    run_req = cfg_reg[`DSS_R_CTRL][`DSS_F_RUN];
    start_mode = cfg_reg[`DSS_R_MODE][`DSS_F_START];
    shape = cfg_reg[`DSS_R_MODE][`DSS_F_SHAPE];
    stop_mode = cfg_reg[`DSS_R_MODE][`DSS_F_STOP];
    bmeth = cfg_reg[`DSS_R_MODE][`DSS_F_BMETH];
    treat = cfg_reg[`DSS_R_MODE][`DSS_F_TREAT];
    ref_f = cfg_reg[`DSS_R_FREF][`DSS_LO];
    fstart = cfg_reg[`DSS_R_FSTART][`DSS_LO];
    f_lo = cfg_reg[`DSS_R_FLIM][`DSS_LO];
    f_hi = cfg_reg[`DSS_R_FLIM][`DSS_HI];
    fmax = cfg_reg[`DSS_R_FMAX][`DSS_LO];
    cur_max = cfg_reg[`DSS_R_BRKC][`DSS_F_PTYPE] ? `DSS_CUR_P : `DSS_CUR_G;
    sb_cur = umin(cfg_reg[`DSS_R_SBRK][`DSS_LO], cur_max);
    sb_t = 16'(umin(cfg_reg[`DSS_R_SBRK][`DSS_HI], `DSS_TIME_MAX) * `DSS_TPS);
    tb_cur = umin(cfg_reg[`DSS_R_TBRK][`DSS_LO], cur_max);
    tb_t = 16'(umin(cfg_reg[`DSS_R_TBRK][`DSS_HI], `DSS_TIME_MAX) * `DSS_TPS);
    fbrk = umin(cfg_reg[`DSS_R_TBFQ][`DSS_LO], umin(`DSS_FBRK_CAP, f_hi));
    bwait = umin(cfg_reg[`DSS_R_TBFQ][`DSS_HI], `DSS_WAIT_MAX);
    hold_t = 16'(umin(cfg_reg[`DSS_R_FSTART][`DSS_HI], `DSS_HOLD_MAX) * `DSS_TPS);
    sc_init = umax(umin(cfg_reg[`DSS_R_SCRV][`DSS_LO], `DSS_SC_IMAX), `DSS_SC_IMIN);
    sc_rise = umax(umin(cfg_reg[`DSS_R_SCRV][`DSS_HI], `DSS_SC_RMAX), `DSS_SC_RMIN);
    // reserved shapes and oversize shares fall back to linear
    sc_ok = (shape == 2'h1) && ((sc_init + sc_rise) <= `DSS_SC_SUM);
    thr = umax(umin(cfg_reg[`DSS_R_BRKC][`DSS_LO], `DSS_THR_MAX), `DSS_THR_MIN);
    tf_t = 16'(umax(umin(cfg_reg[`DSS_R_TFREE][`DSS_LO], `DSS_TF_MAX), `DSS_TF_MIN)
      * `DSS_TPS);
    acc_t = umax(cfg_reg[`DSS_R_RAMP][`DSS_LO], 16'h0001);
    dec_t = umax(cfg_reg[`DSS_R_RAMP][`DSS_HI], 16'h0001);
  end

  // ----------------------------------------------------------------
  // time base in 10 ms ticks
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      tick_cnt_reg <= 32'h0000_0000;
    else if (tick)
      tick_cnt_reg <= 32'h0000_0000;
    else
      tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
  end

  assign tick = (tick_cnt_reg == 32'(CS_CYC - 1));

  // phase timer restarts on every state change and saturates
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      tmr_reg <= 16'h0000;
    else if (st_next != st_reg)
      tmr_reg <= 16'h0000;
    else if (tick && tmr_reg != 16'hFFFF)
      tmr_reg <= tmr_reg + 16'h0001;
  end

  // ----------------------------------------------------------------
  // start/stop state machine
  // ----------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;
    case (st_reg)
      DSS_IDLE:
        if (run_req & ~alarm_reg & ~pend_reg)
          st_next = (start_mode == 2'h1 && sb_t != 16'h0000) ? DSS_SDC : DSS_SHOLD;
      // a stop during the start phases is honoured at once, not after the hold
      DSS_SDC:
        if (!run_req)
          st_next = DSS_IDLE;
        else if (tmr_reg >= sb_t)
          st_next = DSS_SHOLD;
      DSS_SHOLD:
        if (!run_req)
          st_next = (stop_mode == 2'h1) ? DSS_IDLE : DSS_DECEL;
        else if (ref_f < fstart || tmr_reg >= hold_t)
          st_next = DSS_RUN;
      DSS_RUN:
        if (!run_req)
          st_next = (stop_mode == 2'h1) ? DSS_IDLE : DSS_DECEL;
      DSS_DECEL:
        if (run_req)
          st_next = DSS_RUN;
        else if (stop_mode == 2'h2 && tb_t != 16'h0000 && freq_reg <= fbrk)
          st_next = DSS_BWAIT;
        else if (freq_reg == 16'h0000)
          st_next = DSS_IDLE;
      DSS_BWAIT:
        if (tmr_reg >= bwait)
          st_next = DSS_TDC;
      DSS_TDC:
        if (tmr_reg >= tb_t)
          st_next = DSS_IDLE;
      default:
        st_next = DSS_IDLE;
    endcase
    if (pend_reg)
      st_next = DSS_IDLE;
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      st_reg <= DSS_IDLE;
    else
      st_reg <= st_next;
  end

  // ----------------------------------------------------------------
  // ramp generator
  // ----------------------------------------------------------------
  // run target: below start frequency means zero speed, else limits
  always_comb
  begin
    if (st_reg == DSS_DECEL)
      target = 16'h0000;
    else if (ref_f < fstart)
      target = 16'h0000;
    else
      target = umax(umin(ref_f, f_hi), f_lo);
  end

  // one step of 0.01 Hz whenever the scaled rate fills the accumulator
  always_comb
  begin
    den = 48'((freq_reg < target) ? acc_t : dec_t) * 48'(CS_CYC) * 48'(`DSS_TPS)
      * 48'(`DSS_KFULL);
    inc = 48'(fmax) * 48'(sc_ok ? k_reg : `DSS_KFULL);
    done = 32'((freq_reg > org_reg) ? freq_reg - org_reg : org_reg - freq_reg);
    span = 32'((target > org_reg) ? target - org_reg : org_reg - target);
    ph1 = (done * `DSS_PERMIL) < (span * 32'(sc_init));
    ph3 = ((span - done) * `DSS_PERMIL)
      < (span * (`DSS_PERMIL - 32'(sc_init) - 32'(sc_rise)));
  end

  // frequency command; undervoltage alarm forces zero speed
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      freq_reg <= 16'h0000;
      acc_reg <= 48'h0;
      org_reg <= 16'h0000;
    end
    else if (alarm_reg || !(st_reg inside {DSS_SHOLD, DSS_RUN, DSS_DECEL}))
    begin
      freq_reg <= 16'h0000;
      acc_reg <= 48'h0;
      org_reg <= 16'h0000;
    end
    else if (st_reg == DSS_SHOLD)
    begin
      freq_reg <= (ref_f < fstart) ? 16'h0000 : fstart;
      org_reg <= (ref_f < fstart) ? 16'h0000 : fstart;
    end
    else if (freq_reg == target)
    begin
      acc_reg <= 48'h0;
      org_reg <= freq_reg;
    end
    else if (acc_reg + inc >= den)
    begin
      acc_reg <= acc_reg + inc - den;
      freq_reg <= (freq_reg < target) ? freq_reg + 16'h0001 : freq_reg - 16'h0001;
    end
    else
      acc_reg <= acc_reg + inc;
  end

  // S-curve slope weight: rises per step, holds full, then falls
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      k_reg <= 7'h01;
    else if (freq_reg == target || st_reg == DSS_SHOLD)
      k_reg <= 7'h01;
    else if (acc_reg + inc >= den)
    begin
      if (ph1 && k_reg < `DSS_KFULL)
        k_reg <= k_reg + 7'h01;
      // taper only over the last steps, otherwise the tail crawls at weight one
      else if (ph3 && k_reg > 7'h01 && (span - done) <= 32'(k_reg))
        k_reg <= k_reg - 7'h01;
      else if (!ph1 && !ph3)
        k_reg <= `DSS_KFULL;
    end
  end

  // ----------------------------------------------------------------
  // undervoltage trip-free handling
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      uv_tmr_reg <= 16'h0000;
    else if (!undervolt_i)
      uv_tmr_reg <= 16'h0000;
    else if (tick && uv_tmr_reg != 16'hFFFF)
      uv_tmr_reg <= uv_tmr_reg + 16'h0001;
  end

  // treatment 3 is unassigned and behaves like immediate fault
  assign uv_trip = undervolt_i && (st_reg != DSS_IDLE) && (treat != 2'h2)
    && (treat != 2'h1 || uv_tmr_reg >= tf_t);

  // alarm follows the supply; it clears when voltage recovers
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      alarm_reg <= 1'b0;
    else
      alarm_reg <= undervolt_i;
  end

  // pending trip is reported only once the bus is at or above loss level
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pend_reg <= 1'b0;
      fault_reg <= 1'b0;
      rec_reg <= 1'b0;
    end
    else
    begin
      rec_reg <= pend_reg & ~fault_reg & (bus_volt_i >= `DSS_LOSS_V);
      if (uv_trip)
        pend_reg <= 1'b1;
      else if (fclr)
        pend_reg <= 1'b0;
      if (pend_reg & ~fault_reg & (bus_volt_i >= `DSS_LOSS_V))
        fault_reg <= 1'b1;
      else if (fclr & ~uv_trip)
        fault_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // braking and inverter requests
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      brake_reg <= '0;
      inhibit_reg <= 1'b1;
    end
    else
    begin
      brake_reg.dc_on <= (st_reg == DSS_SDC) || (st_reg == DSS_TDC);
      brake_reg.dc_level <= (st_reg == DSS_SDC) ? sb_cur
        : (st_reg == DSS_TDC) ? tb_cur : 16'h0000;
      // method 3 engages only while decelerating
      brake_reg.res_on <= (st_reg != DSS_IDLE)
        && (bmeth == 2'h1 || (bmeth == 2'h3 && st_reg == DSS_DECEL))
        && (bus_volt_i >= (cfg_reg[`DSS_R_BRKC][`DSS_F_LARGE] ? `DSS_THR_LARGE : thr));
      brake_reg.flux_on <= (st_reg == DSS_DECEL) && bmeth[1];
      brake_reg.duty <= cfg_reg[`DSS_R_BRKC][`DSS_F_LARGE]
        ? umin(cfg_reg[`DSS_R_BRKC][`DSS_LO], `DSS_CUR_G) : `DSS_CUR_G;
      inhibit_reg <= alarm_reg || (st_reg inside {DSS_IDLE, DSS_BWAIT});
    end
  end

  assign freq_cmd_o = freq_reg;
  assign brake_o = brake_reg;
  assign pwm_inhibit_o = inhibit_reg;
  assign undervolt_alarm_o = alarm_reg;
  assign undervolt_fault_o = fault_reg;
  assign fault_record_o = rec_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_enter_tdc;
    (st_reg == DSS_BWAIT) ##1 (st_reg == DSS_TDC);
  endsequence

  property p_coast;
    (st_reg == DSS_RUN && !run_req && stop_mode == 2'h1 && !pend_reg)
      |=> (st_reg == DSS_IDLE) ##1 (freq_reg == 16'h0000 && pwm_inhibit_o);
  endproperty
  a_coast: assert property (p_coast) else $error("coast stop did not cut output");

  property p_start_sel;
    (st_reg == DSS_IDLE && st_next == DSS_SDC) |-> (start_mode == 2'h1 && sb_t != 16'h0000);
  endproperty
  a_start_sel: assert property (p_start_sel) else $error("start braking outside mode one");

  property p_hold;
    (st_reg == DSS_SHOLD && ref_f >= fstart && !alarm_reg) |=> (freq_reg == $past(fstart));
  endproperty
  a_hold: assert property (p_hold) else $error("start frequency not applied");

  property p_step;
    (st_reg inside {DSS_RUN, DSS_DECEL} && !alarm_reg)
      |=> (freq_reg - $past(freq_reg) <= 16'h0001 || $past(freq_reg) - freq_reg <= 16'h0001);
  endproperty
  a_step: assert property (p_step) else $error("ramp jumped more than one step");

  property p_uv_zero;
    alarm_reg |=> (freq_reg == 16'h0000) ##1 pwm_inhibit_o;
  endproperty
  a_uv_zero: assert property (p_uv_zero) else $error("undervoltage did not stop output");

  property p_block;
    (alarm_reg && st_reg == DSS_IDLE) |=> (st_reg == DSS_IDLE);
  endproperty
  a_block: assert property (p_block) else $error("start during undervoltage alarm");

  property p_lowv;
    (bus_volt_i < `DSS_LOSS_V) |=> !fault_record_o;
  endproperty
  a_lowv: assert property (p_lowv) else $error("fault recorded below loss voltage");

  property p_tdc;
    s_enter_tdc |=> (brake_o.dc_on && brake_o.dc_level == $past(tb_cur) && freq_cmd_o == 16'h0000);
  endproperty
  a_tdc: assert property (p_tdc) else $error("stop braking not applied");

  property p_fbrk;
    (st_reg == DSS_DECEL && !run_req && !pend_reg && stop_mode == 2'h2 && tb_t != 16'h0000
      && freq_reg <= fbrk)
      |=> (st_reg == DSS_BWAIT && $past(freq_reg) <= `DSS_FBRK_CAP
      && $past(freq_reg) <= $past(f_hi));
  endproperty
  a_fbrk: assert property (p_fbrk) else $error("stop braking above its frequency");

endmodule

// file: bench/dss_power_model.sv
// model of the inverter stage: dc bus voltage and undervoltage sense
`timescale 1ns/1ps
module dss_power_model (
  input wire logic core_clk_i,
  input wire logic sag_i,
  output logic [15:0] bus_volt_o = 16'h021C,
  output logic undervolt_o = 1'b0
);
  // a sag drops the bus below the loss level, so no fault may be recorded yet
  always @(posedge core_clk_i)
  begin
    bus_volt_o <= sag_i ? 16'h00FA : 16'h021C;
    undervolt_o <= sag_i;
  end
endmodule

// file: bench/dss_sequencer_tb.sv
// self-checking bench of the drive start/stop sequencer
`timescale 1ns/1ps
module dss_sequencer_tb;
  import dss_pkg::*;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  logic core_clk_i = 0, rst_i = 1, rd_r = 0, wr_r = 0, sag = 0, pk = 0, uv, wq, inh, al, flt, rec;
  logic [7:0] adr = 0;
  logic [31:0] wd = 0, rdata, pw, sv;
  logic [15:0] fv, volt, f0, f1, f2, fr;
  dss_brake_t brk;
  logic [63:0] q[$];
  int mismatches = 0, total_checks = 0, rec_cnt = 0, dc_cnt = 0, seed = 77010, n, s, d;
  logic [7:0] ra[8] = '{8'h04, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h28, 8'h2C, 8'h30};
  logic [31:0] rv[8] = '{32'h0000_0040, 32'h0000_0032, 32'h1388_0000, 32'h0000_1388,
    32'h003C_003C, 32'h0258_00C8, 32'h0000_02BC, 32'h0000_0014};
  initial
  begin
    forever #25 core_clk_i = ~core_clk_i;
  end
  dss_sequencer #(.CS_CYC(10)) dss_sequencer_i (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .avs_address_i(adr), .avs_read_i(rd_r), .avs_write_i(wr_r), .avs_writedata_i(wd),
    .avs_byteenable_i(4'hF), .avs_readdata_o(rdata), .avs_waitrequest_o(wq),
    .bus_volt_i(volt), .undervolt_i(uv), .freq_cmd_o(fv), .brake_o(brk),
    .pwm_inhibit_o(inh), .undervolt_alarm_o(al), .undervolt_fault_o(flt),
    .fault_record_o(rec));
  dss_power_model dss_power_model_i (.core_clk_i(core_clk_i), .sag_i(sag),
    .bus_volt_o(volt), .undervolt_o(uv));
  assign pw = {brk.dc_level[11:0], brk.dc_on, flt, al, inh, fv};
  // monitor: oldest note is compared with read data or a port snapshot
  always @(posedge core_clk_i)
  begin
    if (rec === 1'b1) rec_cnt++;
    if (brk.dc_on === 1'b1) dc_cnt++;
    if ((rd_r && wq === 1'b0) || pk)
    begin
      sv = rd_r ? rdata : pw;
      total_checks++;
      if (((sv ^ q[0][31:0]) & q[0][63:32]) !== 0)
      begin
        mismatches++;
        $display("CHECK FAILED %0t got %h exp %h", $time, sv, q[0][31:0]);
      end
      void'(q.pop_front());
    end
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic tally(input bit ok);
    total_checks++;
    if (!ok)
    begin
      mismatches++;
      $display("CHECK FAILED %0t bad relation", $time);
    end
  endtask
  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] dt, m);
    int k;
    @(posedge core_clk_i);
    adr <= a;
    wd <= w ? dt : 32'h0;
    wr_r <= w;
    rd_r <= !w;
    if (!w) q.push_back({m, dt});
    k = 0;
    do
    begin
      @(posedge core_clk_i);
      k++;
    end
    while (wq !== 1'b0 && k < 64);
    rd_r <= 0;
    wr_r <= 0;
    if (k == 64) tally(0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dt);
    bus(1, a, dt, 0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
    bus(0, a, e, m);
  endtask
  task automatic peek(input logic [31:0] e, m);
    q.push_back({m, e});
    @(posedge core_clk_i);
    pk <= 1;
    @(posedge core_clk_i);
    pk <= 0;
  endtask
  // bounded wait: 0 freq equal, 1 dc braking on/off, 2 freq above, 3 freq at or below
  task automatic wait_until(input int what, input logic [15:0] f);
    n = 0;
    while (!(what == 0 ? fv === f : what == 1 ? brk.dc_on === f[0] :
      what == 2 ? fv > f : fv <= f) && n < 30000)
    begin
      @(posedge core_clk_i);
      n++;
    end
    if (n == 30000) tally(0);
  endtask
  function automatic logic [31:0] md(input logic [1:0] st, sh, sp, tr);
    return {22'h0, tr, 2'h1, sp, sh, st};
  endfunction
  task automatic finish_test;
    $display("TB: checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    repeat (16) @(posedge core_clk_i);
    rst_i <= 0;
    for (int i = 0; i < 8; i++) rd(ra[i], rv[i], '1);  // defaults
    rd(8'h3C, 0, '1);
    rd(8'h40, 0, '1);
    wr(8'h38, '1);
    rd(8'h38, 0, '1);
    $display("TB: reset test done");
    wr(8'h10, 32'h1388_0064);
    wr(8'h1C, 32'h0001_07FF);
    wr(8'h0C, 32'h0001_0032);
    wr(8'h04, md(1, 0, 1, 0));
    wr(8'h08, 32'h0000_03E8);
    for (s = 0; s < 2; s++)
    begin
      wr(8'h2C, {14'h0, s[0], 17'h002BC});
      wr(8'h00, 1);
      wait_until(1, 1);
      peek({s ? 12'h320 : 12'h3E8, 4'h8, 16'h0}, 32'hFFF8_FFFF);
      wait_until(1, 0);
      repeat (3) @(posedge core_clk_i);
      peek(32'h0000_0032, 32'h0000_FFFF);  // start freq under lower limit
      wr(8'h00, 0);
      repeat (3) @(posedge core_clk_i);
      peek(32'h0001_0000, 32'h0001_FFFF);  // coast at once
    end
    $display("TB: start braking test done");
    wr(8'h04, md(0, 0, 1, 0));
    wr(8'h0C, 32'h0000_0032);
    wr(8'h08, 32'h0000_001E);
    wr(8'h00, 1);
    repeat (300) @(posedge core_clk_i);
    peek(0, 32'h0008_FFFF);  // reference below start freq
    wr(8'h00, 0);
    // random reference, every ramp shape including the reserved ones
    fr = 16'h05DC + 16'($random(seed) & 32'h1FF);
    wr(8'h18, 32'h0064_0064);
    wr(8'h08, {16'h0, fr});
    for (s = 0; s < 4; s++)
    begin
      wr(8'h04, md(0, s[1:0], 1, 0));
      wr(8'h00, 1);
      wait_until(2, 16'h0032);
      f0 = fv;
      repeat (400) @(posedge core_clk_i);
      f1 = fv;
      repeat (400) @(posedge core_clk_i);
      f2 = fv;
      if (s == 1) tally(f2 - f1 > f1 - f0 + 4);
      else tally(f1 - f0 inside {[195:205]} && f2 - f1 inside {[195:205]});
      wait_until(0, fr);
      wr(8'h00, 0);
      wait_until(0, 0);
    end
    $display("TB: ramp test done");
    wr(8'h08, 32'h0000_0190);
    wr(8'h24, 32'h0005_00C8);
    wr(8'h20, 32'h0001_01F4);
    for (s = 0; s < 3; s++)
    begin
      wr(8'h04, md(0, 0, s ? 2'h2 : 2'h0, 0) | (s ? 32'h0 : 32'h80));  // both brakes in mode 0
      if (s == 2) wr(8'h20, 32'h0000_01F4);
      wr(8'h00, 1);
      wait_until(0, 16'h0190);
      d = dc_cnt;
      wr(8'h00, 0);
      if (s == 1)
      begin
        wait_until(3, 16'h00C8);
        wait_until(1, 1);
        tally(n >= 44 && n <= 60);  // wait before injection
        peek(32'h1F48_0000, 32'hFFF8_FFFF);
        wait_until(1, 0);
      end
      else
      begin
        if (s == 0)
        begin
          wait_until(3, 16'h012C);
          tally(brk.flux_on === 1'b1);  // flux braking while decelerating
        end
        wait_until(0, 0);
        repeat (20) @(posedge core_clk_i);
        tally(dc_cnt == d);  // no dc braking: stop mode 0 has none, zero time disables it in mode 2
        peek(32'h0001_0000, 32'h0009_FFFF);  // output ended at zero
      end
      rd(8'h34, 0, 32'h7);
    end
    $display("TB: stop test done");
    wr(8'h2C, 32'h0001_0190);
    repeat (2) @(posedge core_clk_i);
    tally(brk.duty === 16'h0190);  // large unit duty ratio
    wr(8'h2C, 32'h0000_0168);
    wr(8'h04, md(0, 0, 1, 0));
    wr(8'h00, 1);
    wait_until(0, 16'h0190);
    tally(brk.res_on === 1'b1 && brk.flux_on === 1'b0);  // over threshold
    sag <= 1;
    repeat (4) @(posedge core_clk_i);
    peek(32'h0003_0000, 32'h0007_FFFF);
    sag <= 0;
    repeat (4) @(posedge core_clk_i);
    peek(32'h0004_0000, 32'h0006_0000);
    tally(rec_cnt == 1);
    wr(8'h00, 2);
    rd(8'h34, 0, 32'h30);
    wr(8'h04, md(0, 0, 1, 2));
    sag <= 1;
    wr(8'h00, 1);
    repeat (50) @(posedge core_clk_i);
    peek(32'h0002_0000, 32'h0006_FFFF);  // alarm only, start blocked
    wr(8'h00, 0);
    sag <= 0;
    wr(8'h04, md(0, 0, 1, 1));
    wr(8'h00, 1);
    wait_until(0, 16'h0190);
    sag <= 1;
    repeat (50) @(posedge core_clk_i);
    peek(32'h0003_0000, 32'h0007_FFFF);  // alarm only inside the window
    rd(8'h34, 32'h0000_0003, 32'h0000_0047);  // still running, no trip
    sag <= 0;
    wr(8'h00, 0);
    $display("TB: undervoltage test done");
    finish_test;
  end
  // watchdog against a hang
  initial
  begin
    #(50 * 90000);
    mismatches++;
    finish_test;
  end
endmodule
